//--- verilog/pdwe_pkg.sv
// shared constants and carrier types of the waveform port block
package pdwe_pkg;
	localparam int NLINE = 32;
	localparam int NPFT  = 16;
	localparam int NSYNC = 8;
	localparam int AW_BUS = 8;

	// register byte addresses
	localparam logic [7:0] A_DIR     = 8'h00;
	localparam logic [7:0] A_WAVE    = 8'h04;
	localparam logic [7:0] A_SOUT    = 8'h08;
	localparam logic [7:0] A_SIN     = 8'h0C;
	localparam logic [7:0] A_IN_CLK  = 8'h10;
	localparam logic [7:0] A_OUT_CLK = 8'h14;
	localparam logic [7:0] A_STATUS  = 8'h18;
	localparam logic [7:0] A_CTRL    = 8'h1C;

	// status fields
	localparam int ST_OVF     = 0;
	localparam int ST_UNF     = 1;
	localparam int ST_OVR     = 2;
	localparam int ST_ACQ_CNT = 8;
	localparam int ST_GEN_CNT = 16;

	// control fields
	localparam int CT_ACQ_EN    = 0;
	localparam int CT_GEN_EN    = 1;
	localparam int CT_ACQ_FLUSH = 2;
	localparam int CT_GEN_FLUSH = 3;

	localparam int CK_CFG_W = 13;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	// sample clock source codes
	localparam logic [5:0] SRC_AI_SMP = 6'h00;
	localparam logic [5:0] SRC_AI_CNV = 6'h01;
	localparam logic [5:0] SRC_AO_SMP = 6'h02;
	localparam logic [5:0] SRC_CTR0   = 6'h03;
	localparam logic [5:0] SRC_CTR1   = 6'h04;
	localparam logic [5:0] SRC_FREQ   = 6'h05;
	localparam logic [5:0] SRC_CHG    = 6'h06;
	localparam logic [5:0] SRC_STAR   = 6'h07;
	localparam logic [5:0] SRC_CMP    = 6'h08;
	localparam logic [5:0] SRC_PFT0   = 6'h10;
	localparam logic [5:0] SRC_SYNC0  = 6'h20;

	// sample clock configuration, listed from bit 12 down to bit 0
	typedef struct packed {
		logic       retx;
		logic [3:0] pft;
		logic       export_en;
		logic       fall;
		logic [5:0] src;
	} pdwe_clk_cfg_s;

	// routed candidate clock sources
	typedef struct packed {
		logic [NSYNC-1:0] sync_bus_line;
		logic [NPFT-1:0]  programmable_function_terminal;
		logic             analog_cmp_event;
		logic             backplane_star_trigger;
		logic             input_change_event;
		logic             freq_gen_out;
		logic [1:0]       counter_out;
		logic             analog_out_sample_clock;
		logic             analog_in_convert_clock;
		logic             analog_in_sample_clock;
	} pdwe_src_s;
endpackage

//--- verilog/pdwe_top.sv
// 32-line digital port: static io, waveform capture and generation
// Notes on behaviour
// - thirty-two bidirectional main port lines, each input or output
// - capture side: line is output, static input or waveform input
// - generation side: line is input, static output or waveform output
// - static reads and writes happen only on software register access
// - lines 6 and 7 also feed counter direction, input only
// - waveforms start only when the chosen clock source pulses
// - each input sample edge stores all 32 lines as one word
// - input sample clock edge is rising or falling by choice
// - input sample clock has no divider, always a routed source
// - input clock picks internal sources with selectable polarity
// - input clock may also come from terminals, sync bus, star, compare
// - input edge while capture fifo full raises overflow flag
// - dma channel drains capture fifo to host memory
// - exported input sample clock drives terminal inverted
// - each output sample edge drives next generation word onto lines
// - retransmit replays the stored words in order forever
// - output edge while generation fifo empty raises underflow flag
// - output clock has no divider, same internal sources, polarity
// - output clock also from external sources, rising or falling
// - output edges too close for next fetch raise overrun flag
// - dma channel fills generation fifo from host memory
// - exported output sample clock drives terminal inverted
// - after reset every line is an undriven input
`timescale 1ns/100ps
module pdwe_top #(
	parameter int DEPTH = 16
) (
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_resetn,
	input  wire logic [7:0]                   i_addr,
	input  wire logic [31:0]                  i_wdata,
	input  wire logic                         i_wr,
	input  wire logic                         i_rd,
	output logic      [31:0]                  o_rdata,
	input  wire logic [pdwe_pkg::NLINE-1:0]   i_main_port_lines,
	output logic      [pdwe_pkg::NLINE-1:0]   o_main_port_lines,
	output logic      [pdwe_pkg::NLINE-1:0]   o_main_port_oe_n,
	input  wire pdwe_pkg::pdwe_src_s          i_src,
	output logic      [pdwe_pkg::NPFT-1:0]    o_pft_out,
	output logic      [pdwe_pkg::NPFT-1:0]    o_pft_oe_n,
	output logic      [1:0]                   o_ctr_dir,
	output logic                              o_acq_valid,
	output logic      [pdwe_pkg::NLINE-1:0]   o_acq_data,
	input  wire logic                         i_acq_ready,
	input  wire logic                         i_gen_valid,
	input  wire logic [pdwe_pkg::NLINE-1:0]   i_gen_data,
	output logic                              o_gen_ready
);
	import pdwe_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	// pick one routed source; no timebase divider exists on this path
	function automatic logic src_pick(input logic [5:0] sel,
	                                  input pdwe_src_s s);
		logic [63:0] v;
		v = '0;
		v[SRC_AI_SMP] = s.analog_in_sample_clock;
		v[SRC_AI_CNV] = s.analog_in_convert_clock;
		v[SRC_AO_SMP] = s.analog_out_sample_clock;
		v[SRC_CTR0]   = s.counter_out[0];
		v[SRC_CTR1]   = s.counter_out[1];
		v[SRC_FREQ]   = s.freq_gen_out;
		v[SRC_CHG]    = s.input_change_event;
		v[SRC_STAR]   = s.backplane_star_trigger;
		v[SRC_CMP]    = s.analog_cmp_event;
		v[SRC_PFT0 +: NPFT]  = s.programmable_function_terminal;
		v[SRC_SYNC0 +: NSYNC] = s.sync_bus_line;
		return v[sel];
	endfunction

	logic [NLINE-1:0] dir_r, wave_r, sout_r;
	pdwe_clk_cfg_s    in_cfg_r, out_cfg_r;
	logic             acq_en_r, gen_en_r, acq_flush, gen_flush;
	logic             ovf_r, unf_r, ovr_r;
	logic             wr_dir, wr_st, wr_ct;

	assign wr_dir    = i_wr && i_addr == A_DIR;
	assign wr_st     = i_wr && i_addr == A_STATUS;
	assign wr_ct     = i_wr && i_addr == A_CTRL;
	assign acq_flush = wr_ct && i_wdata[CT_ACQ_FLUSH];
	assign gen_flush = wr_ct && i_wdata[CT_GEN_FLUSH];

	// software-written configuration
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			dir_r     <= RST_ZERO;
			wave_r    <= RST_ZERO;
			sout_r    <= RST_ZERO;
			in_cfg_r  <= '0;
			out_cfg_r <= '0;
			acq_en_r  <= 1'b0;
			gen_en_r  <= 1'b0;
		end else begin
			if (wr_dir)
				dir_r <= i_wdata;
			if (i_wr && i_addr == A_WAVE)
				wave_r <= i_wdata;
			if (i_wr && i_addr == A_SOUT)
				sout_r <= i_wdata;
			if (i_wr && i_addr == A_IN_CLK)
				in_cfg_r <= pdwe_clk_cfg_s'(i_wdata[CK_CFG_W-1:0]);
			if (i_wr && i_addr == A_OUT_CLK)
				out_cfg_r <= pdwe_clk_cfg_s'(i_wdata[CK_CFG_W-1:0]);
			if (wr_ct) begin
				acq_en_r <= i_wdata[CT_ACQ_EN];
				gen_en_r <= i_wdata[CT_GEN_EN];
			end
		end
	end

	// pin and clock synchronisers; a level counts once stages 2 and 3 agree
	logic [NLINE-1:0] ln_s1, ln_s2, ln_s3, ln_lev;
	logic [1:0]       ck_s1, ck_s2, ck_s3, ck_lev, ck_prev;
	logic [1:0]       ck_pol;
	logic             in_stb, out_stb;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			ln_s1 <= RST_ZERO;
			ln_s2 <= RST_ZERO;
			ln_s3 <= RST_ZERO;
			ln_lev <= RST_ZERO;
			ck_s1 <= 2'h0;
			ck_s2 <= 2'h0;
			ck_s3 <= 2'h0;
			ck_lev <= 2'h0;
			ck_prev <= 2'h0;
		end else begin
			ln_s1 <= i_main_port_lines;
			ln_s2 <= ln_s1;
			ln_s3 <= ln_s2;
			ln_lev <= (ln_s3 & ~(ln_s2 ^ ln_s3)) | (ln_lev & (ln_s2 ^ ln_s3));
			ck_s1 <= {src_pick(out_cfg_r.src, i_src),
			          src_pick(in_cfg_r.src, i_src)};
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			ck_lev <= (ck_s3 & ~(ck_s2 ^ ck_s3)) | (ck_lev & (ck_s2 ^ ck_s3));
			ck_prev <= ck_pol;
		end
	end

	// polarity folds into the level so one rising detector serves both edges
	assign ck_pol  = ck_lev ^ {out_cfg_r.fall, in_cfg_r.fall};
	assign in_stb  = ck_pol[0] & ~ck_prev[0];
	assign out_stb = ck_pol[1] & ~ck_prev[1];

	// capture fifo
	logic [NLINE-1:0] amem [DEPTH];
	logic [AW-1:0]    acq_wp, acq_rp;
	logic [AW:0]      acq_cnt;
	logic             acq_push, acq_pop, acq_full;

	assign acq_full = acq_cnt == DEPTH_C;
	// no start trigger: capture begins with the first source pulse
	assign acq_push = in_stb && acq_en_r && !acq_full;
	assign acq_pop  = acq_cnt != '0 && (!o_acq_valid || i_acq_ready);

	always_ff @(posedge i_sys_clk) begin
		if (acq_push)
			amem[acq_wp] <= ln_lev;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || acq_flush) begin
			acq_wp  <= '0;
			acq_rp  <= '0;
			acq_cnt <= '0;
		end else begin
			if (acq_push)
				acq_wp <= acq_wp + 1'b1;
			if (acq_pop)
				acq_rp <= acq_rp + 1'b1;
			acq_cnt <= acq_cnt + (AW+1)'(acq_push) - (AW+1)'(acq_pop);
		end
	end

	// dma output stage toward host memory
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || acq_flush) begin
			o_acq_valid <= 1'b0;
			o_acq_data  <= RST_ZERO;
		end else if (acq_pop) begin
			o_acq_valid <= 1'b1;
			o_acq_data  <= amem[acq_rp];
		end else if (i_acq_ready) begin
			o_acq_valid <= 1'b0;
		end
	end

	// generation fifo; retransmit walks an offset instead of popping
	logic [NLINE-1:0] gmem [DEPTH];
	logic [AW-1:0]    gen_wp, gen_rp, rt_ofs, rt_idx;
	logic [AW:0]      gen_cnt, gen_cnt_nxt;
	logic             gen_push, gen_pop, fetch, nxt_vld_r;
	logic [NLINE-1:0] nxt_word_r, gen_word_r;
	logic             gen_fire;

	assign gen_push = i_gen_valid && o_gen_ready;
	assign gen_fire = out_stb && gen_en_r && nxt_vld_r;
	assign fetch    = gen_cnt != '0 && (!nxt_vld_r || gen_fire);
	assign gen_pop  = fetch && !out_cfg_r.retx;
	assign gen_cnt_nxt = gen_cnt + (AW+1)'(gen_push) - (AW+1)'(gen_pop);
	// count may grow after a wrap, so the wrap is decided at each fetch
	assign rt_idx = ({1'b0, rt_ofs} < gen_cnt) ? rt_ofs : '0;

	always_ff @(posedge i_sys_clk) begin
		if (gen_push)
			gmem[gen_wp] <= i_gen_data;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || gen_flush) begin
			gen_wp  <= '0;
			gen_rp  <= '0;
			rt_ofs  <= '0;
			gen_cnt <= '0;
			o_gen_ready <= 1'b0;
		end else begin
			if (gen_push)
				gen_wp <= gen_wp + 1'b1;
			if (gen_pop)
				gen_rp <= gen_rp + 1'b1;
			if (fetch && out_cfg_r.retx)
				rt_ofs <= rt_idx + 1'b1;
			gen_cnt <= gen_cnt_nxt;
			o_gen_ready <= gen_cnt_nxt != DEPTH_C;
		end
	end

	// prefetched next word; an edge before it lands is an overrun
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn || gen_flush) begin
			nxt_vld_r  <= 1'b0;
			nxt_word_r <= RST_ZERO;
		end else if (fetch) begin
			nxt_vld_r  <= 1'b1;
			nxt_word_r <= gmem[gen_rp + rt_idx];
		end else if (gen_fire) begin
			nxt_vld_r  <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn)
			gen_word_r <= RST_ZERO;
		else if (gen_fire)
			gen_word_r <= nxt_word_r;
	end

	// sticky errors, write one to clear, a new event wins over the clear
	logic set_ovf, set_unf, set_ovr;
	assign set_ovf = in_stb && acq_en_r && acq_full;
	assign set_unf = out_stb && gen_en_r && !nxt_vld_r &&
	                 gen_cnt == '0;
	assign set_ovr = out_stb && gen_en_r && !nxt_vld_r &&
	                 gen_cnt != '0;

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			ovf_r <= 1'b0;
			unf_r <= 1'b0;
			ovr_r <= 1'b0;
		end else begin
			ovf_r <= (ovf_r && !(wr_st && i_wdata[ST_OVF])) || set_ovf;
			unf_r <= (unf_r && !(wr_st && i_wdata[ST_UNF])) || set_unf;
			ovr_r <= (ovr_r && !(wr_st && i_wdata[ST_OVR])) || set_ovr;
		end
	end

	// register read, data stands in the following cycle only
	logic [31:0] rd_val;
	always_comb begin
		rd_val = RST_ZERO;
		unique case (i_addr)
			A_DIR:     rd_val = dir_r;
			A_WAVE:    rd_val = wave_r;
			A_SOUT:    rd_val = sout_r;
			A_SIN:     rd_val = ln_lev;
			A_IN_CLK:  rd_val[CK_CFG_W-1:0] = in_cfg_r;
			A_OUT_CLK: rd_val[CK_CFG_W-1:0] = out_cfg_r;
			A_STATUS: begin
				rd_val[ST_OVF] = ovf_r;
				rd_val[ST_UNF] = unf_r;
				rd_val[ST_OVR] = ovr_r;
				rd_val[ST_ACQ_CNT +: 8] = 8'(acq_cnt);
				rd_val[ST_GEN_CNT +: 8] = 8'(gen_cnt);
			end
			A_CTRL: begin
				rd_val[CT_ACQ_EN] = acq_en_r;
				rd_val[CT_GEN_EN] = gen_en_r;
			end
			default:   rd_val = RST_ZERO;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn)
			o_rdata <= RST_ZERO;
		else
			o_rdata <= i_rd ? rd_val : RST_ZERO;
	end

	// line drivers; waveform lines take the generated word
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_main_port_lines <= RST_ZERO;
			o_main_port_oe_n  <= '1;
			o_ctr_dir         <= 2'h0;
		end else begin
			o_main_port_lines <= (wave_r & gen_word_r) |
			                     (~wave_r & sout_r);
			o_main_port_oe_n  <= ~dir_r;
			o_ctr_dir         <= ln_lev[7:6];
		end
	end

	// exported clocks are inverted; input clock wins a shared terminal
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_pft_out  <= '0;
			o_pft_oe_n <= '1;
		end else begin
			for (int i = 0; i < NPFT; i++) begin
				if (in_cfg_r.export_en && in_cfg_r.pft == 4'(i)) begin
					o_pft_out[i]  <= ~ck_lev[0];
					o_pft_oe_n[i] <= 1'b0;
				end else if (out_cfg_r.export_en &&
				             out_cfg_r.pft == 4'(i)) begin
					o_pft_out[i]  <= ~ck_lev[1];
					o_pft_oe_n[i] <= 1'b0;
				end else begin
					o_pft_out[i]  <= 1'b0;
					o_pft_oe_n[i] <= 1'b1;
				end
			end
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	a_reset_hiz_lines: assert property (
		$rose(i_resetn) |-> o_main_port_oe_n == '1 && dir_r == '0)
		else $error("lines driven after reset");
	a_overflow_flag_set: assert property (
		set_ovf |=> ovf_r && acq_cnt == $past(acq_cnt) - (AW+1)'($past(acq_pop)))
		else $error("overflow not flagged");
	a_underflow_flag_set: assert property (
		out_stb && gen_en_r && gen_cnt == '0 && !nxt_vld_r |=> unf_r)
		else $error("underflow not flagged");
	a_overrun_flag_set: assert property (
		set_ovr |=> ovr_r && $stable(gen_word_r))
		else $error("overrun not flagged");
	a_capture_word_line: assert property (
		acq_push |=> amem[$past(acq_wp)] == $past(ln_lev))
		else $error("captured word differs from lines");
	a_strobe_single_cyc: assert property (
		in_stb |=> !in_stb ##1 !in_stb)
		else $error("input strobe longer than one cycle");
	a_gen_word_drive: assert property (
		gen_fire && wave_r[0] && dir_r[0] |=> ##1
		o_main_port_lines[0] == $past(nxt_word_r[0], 2))
		else $error("generated word not driven");
	a_static_out_line: assert property (
		1'b1 |=> ((o_main_port_lines ^ $past(sout_r)) & ~$past(wave_r)) == '0)
		else $error("static output mismatch");
	a_in_export_inv: assert property (
		in_cfg_r.export_en && $stable(in_cfg_r) |=>
		o_pft_out[in_cfg_r.pft] == ~$past(ck_lev[0]) &&
		!o_pft_oe_n[in_cfg_r.pft])
		else $error("input clock export not inverted");
	a_ctr_dir_tap: assert property (
		1'b1 |=> o_ctr_dir == $past(ln_lev[7:6]))
		else $error("counter direction tap wrong");
	a_retx_keeps_data: assert property (
		out_cfg_r.retx && fetch && !gen_flush |=> gen_cnt >= $past(gen_cnt))
		else $error("retransmit dropped stored words");

	c_overflow_seen:  cover property (set_ovf);
	c_underflow_seen: cover property (set_unf);
	c_retx_wrap:      cover property (fetch && out_cfg_r.retx &&
	                                  rt_ofs != '0 && rt_idx == '0);
	c_acq_to_dma:     cover property (acq_push ##[1:10]
	                                  o_acq_valid && i_acq_ready);
endmodule

//--- verif/pdwe_host_model.sv
// host dma and routed clock source model for the waveform port
`timescale 1ns/100ps
module pdwe_host_model (
	input  wire logic                       i_clk,
	input  wire logic                       i_acq_valid,
	input  wire logic [pdwe_pkg::NLINE-1:0] i_acq_data,
	input  wire logic                       i_gen_ready,
	output pdwe_pkg::pdwe_src_s             o_src,
	output logic                            o_acq_ready,
	output logic                            o_gen_valid,
	output logic      [pdwe_pkg::NLINE-1:0] o_gen_data
);
	import pdwe_pkg::*;
	logic [32:0]      src_r = '0;
	logic             stall = 1'b0;
	logic [NLINE-1:0] acq_q [$];
	logic [NLINE-1:0] gen_q [$];

	initial begin
		o_acq_ready = 1'b0;
		o_gen_valid = 1'b0;
		o_gen_data  = '0;
	end
	assign o_src = pdwe_src_s'(src_r);

	// ten-cycle phases keep edges far beyond the fetch time
	task automatic drive_src(input int idx, input logic lvl);
		@(posedge i_clk);
		src_r[idx] <= lvl;
		repeat (10) @(posedge i_clk);
	endtask

	always @(posedge i_clk) begin
		if (i_acq_valid && o_acq_ready)
			acq_q.push_back(i_acq_data);
		o_acq_ready <= !stall;
	end

	// idle data bus toggles so a stale word is never mistaken for valid
	always @(posedge i_clk) begin
		if (o_gen_valid && i_gen_ready)
			void'(gen_q.pop_front());
		if (gen_q.size() > 0) begin
			o_gen_valid <= 1'b1;
			o_gen_data  <= gen_q[0];
		end else begin
			o_gen_valid <= 1'b0;
			o_gen_data  <= ~o_gen_data;
		end
	end
endmodule

//--- verif/tb_port_dio_waveform_engine.sv
// self-checking bench of the waveform port block
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module tb_port_dio_waveform_engine;
	import pdwe_pkg::*;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic [7:0]        addr = '0;
	logic [31:0]       wdata = '0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [31:0]       rdata;
	logic [NLINE-1:0]  lines_in = '0;
	logic [NLINE-1:0]  lines_out;
	logic [NLINE-1:0]  oe_n;
	pdwe_src_s         src;
	logic [NPFT-1:0]   pft_out;
	logic [NPFT-1:0]   pft_oe_n;
	logic [1:0]        ctr_dir;
	logic              acq_valid;
	logic [NLINE-1:0]  acq_data;
	logic              acq_ready;
	logic              gen_valid;
	logic [NLINE-1:0]  gen_data;
	logic              gen_ready;
	int                err_total = 0;
	int                compares = 0;
	logic [31:0]       rv;
	logic [31:0]       v;
	logic [5:0]        codes [11];
	logic [31:0]       gw [3] = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003};

	always #2.5 clk = ~clk;

	pdwe_top #(.DEPTH(4)) DUT (
		.i_sys_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_main_port_lines(lines_in),
		.o_main_port_lines(lines_out), .o_main_port_oe_n(oe_n), .i_src(src),
		.o_pft_out(pft_out), .o_pft_oe_n(pft_oe_n), .o_ctr_dir(ctr_dir),
		.o_acq_valid(acq_valid), .o_acq_data(acq_data),
		.i_acq_ready(acq_ready), .i_gen_valid(gen_valid),
		.i_gen_data(gen_data), .o_gen_ready(gen_ready)
	);

	pdwe_host_model PART (
		.i_clk(clk), .i_acq_valid(acq_valid), .i_acq_data(acq_data),
		.i_gen_ready(gen_ready), .o_src(src), .o_acq_ready(acq_ready),
		.o_gen_valid(gen_valid), .o_gen_data(gen_data)
	);

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask

	function automatic int idx_of(input logic [5:0] c);
		if (c >= SRC_SYNC0)
			return 25 + c - SRC_SYNC0;
		if (c >= SRC_PFT0)
			return 9 + c - SRC_PFT0;
		return int'(c);
	endfunction

	// lines change mid-phase so the captured word shows which edge acted
	task automatic pulse(input int idx, input logic [31:0] v1, v2);
		@(posedge clk);
		lines_in <= v1;
		repeat (10) @(posedge clk);
		PART.drive_src(idx, 1'b1);
		lines_in <= v2;
		repeat (10) @(posedge clk);
		PART.drive_src(idx, 1'b0);
	endtask

	task automatic report_and_stop();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		report_and_stop();
	end

	initial begin
		codes = '{SRC_AI_SMP, SRC_AI_CNV, SRC_AO_SMP, SRC_CTR0, SRC_CTR1,
			SRC_FREQ, SRC_CHG, SRC_STAR, SRC_CMP, SRC_PFT0 + 6'h03,
			SRC_SYNC0 + 6'h07};
		repeat (6) @(posedge clk);
		`CHK("oe_n_rst", 32'hFFFF_FFFF, oe_n)
		`CHK("lines_rst", 32'h0, lines_out)
		`CHK("pft_oe_rst", 16'hFFFF, pft_oe_n)
		resetn <= 1'b1;
		@(posedge clk);
		#1 `CHK("gen_ready", 1'b1, gen_ready)
		bus_wr(8'h40, 32'hFFFF_FFFF);
		bus_rd(8'h40, rv);
		`CHK("unmapped", 32'h0, rv)
		bus_rd(A_DIR, rv);
		`CHK("dir_rst", RST_ZERO, rv)
		bus_wr(A_DIR, 32'hFFFF_0000);
		bus_wr(A_SOUT, 32'hA5A5_5A5A);
		repeat (3) @(posedge clk);
		`CHK("oe_n", 32'h0000_FFFF, oe_n)
		`CHK("sout", 16'hA5A5, lines_out[31:16])
		bus_rd(A_DIR, rv);
		`CHK("dir", 32'hFFFF_0000, rv)
		bus_wr(A_DIR, RST_ZERO);
		@(posedge clk);
		lines_in <= 32'h8765_4381;
		repeat (10) @(posedge clk);
		bus_rd(A_SIN, rv);
		`CHK("sin", 32'h8765_4381, rv)
		`CHK("ctr_dir", 2'h2, ctr_dir)
		`CHK("oe_n_in", 32'hFFFF_FFFF, oe_n)
		bus_wr(A_IN_CLK, {26'h0, SRC_STAR});
		bus_wr(A_CTRL, 32'h5);
		repeat (50) @(posedge clk);
		`CHK("idle_words", 0, PART.acq_q.size())
		for (int k = 0; k < 11; k++) begin
			bus_wr(A_CTRL, RST_ZERO);
			bus_wr(A_IN_CLK, {25'h0, k[0], codes[k]});
			repeat (10) @(posedge clk);
			bus_wr(A_CTRL, 32'h5);
			v = 32'h0101_0101 * (k + 1);
			pulse(idx_of(codes[k]), v, ~v);
			repeat (10) @(posedge clk);
			`CHK("words", 1, PART.acq_q.size())
			rv = PART.acq_q.pop_front();
			`CHK("capture", k[0] ? ~v : v, rv)
		end
		bus_wr(A_IN_CLK, {20'h0, 4'h5, 1'b1, 1'b0, SRC_PFT0 + 6'h03});
		PART.drive_src(12, 1'b1);
		`CHK("pft_oe_n", 1'b0, pft_oe_n[5])
		`CHK("pft_hi", 1'b0, pft_out[5])
		PART.drive_src(12, 1'b0);
		`CHK("pft_lo", 1'b1, pft_out[5])
		PART.stall = 1'b1;
		repeat (2) @(posedge clk);
		PART.acq_q.delete();
		bus_wr(A_CTRL, 32'h5);
		for (int k = 0; k < 8; k++) begin
			v = 32'h0101_0101 * (k + 1);
			pulse(12, v, ~v);
		end
		bus_rd(A_STATUS, rv);
		`CHK("overflow", 1'b1, rv[ST_OVF])
		bus_wr(A_STATUS, 32'h7);
		bus_rd(A_STATUS, rv);
		`CHK("ovf_clear", 1'b0, rv[ST_OVF])
		PART.stall = 1'b0;
		repeat (20) @(posedge clk);
		`CHK("first_kept", 32'h0101_0101, PART.acq_q[0])
		bus_wr(A_CTRL, RST_ZERO);
		bus_wr(A_DIR, 32'hFFFF_FFFF);
		bus_wr(A_WAVE, 32'hFFFF_FFFF);
		bus_wr(A_OUT_CLK, {19'h0, 1'b1, 4'h1, 1'b1, 1'b0, SRC_SYNC0 + 6'h02});
		bus_wr(A_CTRL, 32'hA);
		PART.gen_q = '{gw[0], gw[1], gw[2]};
		repeat (20) @(posedge clk);
		for (int k = 0; k < 7; k++) begin
			PART.drive_src(27, 1'b1);
			`CHK("pft1_oe_n", 1'b0, pft_oe_n[1])
			`CHK("pft1_hi", 1'b0, pft_out[1])
			`CHK("gen_word", gw[k % 3], lines_out)
			PART.drive_src(27, 1'b0);
		end
		bus_wr(A_CTRL, RST_ZERO);
		bus_wr(A_OUT_CLK, {26'h0, SRC_FREQ});
		bus_wr(A_CTRL, 32'hA);
		bus_wr(A_STATUS, 32'h7);
		PART.drive_src(5, 1'b1);
		PART.drive_src(5, 1'b0);
		bus_rd(A_STATUS, rv);
		`CHK("underflow", 1'b1, rv[ST_UNF])
		`CHK("no_ovf", 1'b0, rv[ST_OVF])
		`CHK("no_ovr", 1'b0, rv[ST_OVR])
		// word lands in the same cycle as the strobe, prefetch not yet done
		@(posedge clk);
		PART.src_r[5] <= 1'b1;
		repeat (2) @(posedge clk);
		#1 PART.gen_q.push_back(gw[1]);
		repeat (10) @(posedge clk);
		bus_rd(A_STATUS, rv);
		`CHK("overrun", 1'b1, rv[ST_OVR])
		report_and_stop();
	end
endmodule
